/* core/hall_sensor_result_status_regs.v */
// Result and status register bank of a three-axis field sensor, read and written by the serial host.
`timescale 1ns/1ps
`include "hall_result_regs.vh"

// Notes on behaviour
// RULE1: Y result: high byte at 14h, low byte at 15h.
// RULE2: Z result: high byte at 16h, low byte at 17h.
// RULE3: All result bytes read zero after reset until a data set lands.
// RULE4: Conversion state bits 7-5 count completed data sets, wrapping at eight.
// RULE5: Power-on flag bit 4 set by reset, cleared by writing one.
// RULE6: Diagnostic bit 1 reads one when any fault check has failed.
// RULE7: Ready bit 0 is one once a full data set is buffered.
// RULE8: Angle is 13 bits over two bytes, low four bits sixteenths.
// RULE9: Vector size register holds the 8-bit field magnitude.
// RULE10: Fault register bit 4 follows the interrupt pin level, one at reset.
// RULE11: Oscillator fault bit 3 is sticky, cleared by writing one.
// RULE12: Interrupt pin fault bit 2 is sticky, cleared by writing one.
// RULE13: Fuse checksum fault bit 1 is sticky, cleared by writing one.
// RULE14: Supply undervoltage bit 0 is sticky, cleared by writing one.
// RULE15: Zero writes change nothing; read-only writes ignored; reserved bits read zero.
module hall_sensor_result_status_regs #(
    parameter ADDR_W   = 8,
    parameter RESULT_W = `RESULT_W,
    parameter ANGLE_W  = `ANGLE_W
) (
    // Clock and reset
    input  wire                clk_sys_i,
    input  wire                rst_i,
    // Register access from the serial interface
    input  wire                rd_en_i,
    input  wire                wr_en_i,
    input  wire [ADDR_W-1:0]   addr_i,
    input  wire [7:0]          wr_data_i,
    output reg  [7:0]          rd_data_o,
    output reg                 rd_valid_o,
    // Conversion engine
    input  wire                conv_start_i,
    input  wire                set_done_i,
    input  wire [RESULT_W-1:0] y_axis_value_i,
    input  wire [RESULT_W-1:0] z_axis_value_i,
    input  wire [ANGLE_W-1:0]  angle_value_i,
    input  wire [7:0]          vector_size_i,
    // Fault detectors and pin
    input  wire                oscillator_fault_i,
    input  wire                irq_pin_fault_i,
    input  wire                fuse_checksum_fault_i,
    input  wire                supply_undervoltage_fault_i,
    input  wire                irq_pin_level_i,
    // Status mirrors
    output reg                 result_ready_o,
    output reg                 diag_fail_o
);

    // Buffered data set.
    reg [RESULT_W-1:0]           y_axis_value_r;
    reg [RESULT_W-1:0]           z_axis_value_r;
    reg [ANGLE_W-1:0]            angle_value_r;
    reg [7:0]                    vector_size_r;

    // Conversion state fields.
    reg [`SET_COUNT_W-1:0]       set_count_r;
    reg [`SET_COUNT_W-1:0]       set_count_nxt;
    reg                          ready_r;
    reg                          ready_nxt;
    reg                          irq_pin_readback_r;

    // Sticky flags.
    wire                         power_on_flag;
    wire [`FAULT_STICKY_W-1:0]   fault_sticky;
    wire [`FAULT_STICKY_W-1:0]   fault_events;
    wire [`FAULT_STICKY_W-1:0]   fault_clear;
    wire                         power_on_clear;
    wire                         diag_any;

    // Register access decode.
    wire                         wr_conv_state;
    wire                         wr_fault_flags;
    reg  [7:0]                   conv_state_word;
    reg  [7:0]                   fault_flags_word;
    reg  [7:0]                   rd_mux;

    // Write decode: only the two status registers hold writable bits.
    assign wr_conv_state  = wr_en_i && (addr_i == `ADDR_CONV_STATE); // RULE15
    assign wr_fault_flags = wr_en_i && (addr_i == `ADDR_FAULT_FLAGS); // RULE15

    // A one clears, a zero leaves the flag alone.
    assign power_on_clear = wr_conv_state && wr_data_i[`CONV_POWER_ON_BIT]; // RULE5 RULE15

    assign fault_clear[`FAULT_OSC_BIT]      = wr_fault_flags && wr_data_i[`FAULT_OSC_BIT]; // RULE11
    assign fault_clear[`FAULT_IRQ_PIN_BIT]  = wr_fault_flags && wr_data_i[`FAULT_IRQ_PIN_BIT]; // RULE12
    assign fault_clear[`FAULT_FUSE_BIT]     = wr_fault_flags && wr_data_i[`FAULT_FUSE_BIT]; // RULE13
    assign fault_clear[`FAULT_SUPPLY_BIT]   = wr_fault_flags && wr_data_i[`FAULT_SUPPLY_BIT]; // RULE14

    assign fault_events[`FAULT_OSC_BIT]     = oscillator_fault_i; // RULE11
    assign fault_events[`FAULT_IRQ_PIN_BIT] = irq_pin_fault_i; // RULE12
    assign fault_events[`FAULT_FUSE_BIT]    = fuse_checksum_fault_i; // RULE13
    assign fault_events[`FAULT_SUPPLY_BIT]  = supply_undervoltage_fault_i; // RULE14

    // The power-on flag has no run-time source; only reset raises it.
    sticky_flag_bank #(
        .WIDTH     (1),
        .RESET_VAL (`RST_POWER_ON)
    ) u_power_on_flag (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .set_i     (1'b0),
        .clr_i     (power_on_clear),
        .flags_o   (power_on_flag)
    ); // RULE5

    sticky_flag_bank #(
        .WIDTH     (`FAULT_STICKY_W),
        .RESET_VAL (`RST_STICKY_FAULTS)
    ) u_fault_flags (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .set_i     (fault_events),
        .clr_i     (fault_clear),
        .flags_o   (fault_sticky)
    ); // RULE11 RULE12 RULE13 RULE14

    // Summary covers the held flags and any check failing right now, so a
    // fault is visible to a read in the cycle it occurs, one cycle before its sticky bit.
    assign diag_any = (|fault_sticky) || (|fault_events); // RULE6

    // Data set buffer. Results change only when a whole set is done, so a
    // host reading high then low byte between sets always sees one sample.
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            y_axis_value_r <= {RESULT_W{1'b0}}; // RULE3
            z_axis_value_r <= {RESULT_W{1'b0}}; // RULE3
            angle_value_r  <= {ANGLE_W{1'b0}}; // RULE3
            vector_size_r  <= `RST_RESULT_BYTE; // RULE3
        end else if (set_done_i) begin
            y_axis_value_r <= y_axis_value_i; // RULE1
            z_axis_value_r <= z_axis_value_i; // RULE2
            angle_value_r  <= angle_value_i; // RULE8
            vector_size_r  <= vector_size_i; // RULE9
        end
    end

    // Set counter wraps through eight values.
    always @* begin
        set_count_nxt = set_count_r;
        if (set_done_i) begin
            set_count_nxt = set_count_r + 3'h1; // RULE4
        end
    end

    // Ready drops when a new conversion starts and rises when the set lands;
    // a completion in the same cycle as a start wins.
    always @* begin
        ready_nxt = ready_r;
        if (set_done_i) begin
            ready_nxt = 1'b1; // RULE7
        end else if (conv_start_i) begin
            ready_nxt = 1'b0; // RULE7
        end
    end

    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            set_count_r <= `RST_SET_COUNT;
            ready_r     <= 1'b0;
        end else begin
            set_count_r <= set_count_nxt;
            ready_r     <= ready_nxt;
        end
    end

    // Pin readback resets high and then tracks the pin every cycle.
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            irq_pin_readback_r <= `RST_PIN_LEVEL; // RULE10
        end else begin
            irq_pin_readback_r <= irq_pin_level_i; // RULE10
        end
    end

    // Assembled status words; unlisted bits stay zero.
    always @* begin
        conv_state_word = 8'h00; // RULE15
        conv_state_word[`CONV_COUNT_MSB:`CONV_COUNT_LSB] = set_count_r; // RULE4
        conv_state_word[`CONV_POWER_ON_BIT] = power_on_flag; // RULE5
        conv_state_word[`CONV_DIAG_BIT]     = diag_any; // RULE6
        conv_state_word[`CONV_READY_BIT]    = ready_r; // RULE7
    end

    always @* begin
        fault_flags_word = 8'h00; // RULE15
        fault_flags_word[`FAULT_PIN_LEVEL_BIT] = irq_pin_readback_r; // RULE10
        fault_flags_word[`FAULT_OSC_BIT]       = fault_sticky[`FAULT_OSC_BIT]; // RULE11
        fault_flags_word[`FAULT_IRQ_PIN_BIT]   = fault_sticky[`FAULT_IRQ_PIN_BIT]; // RULE12
        fault_flags_word[`FAULT_FUSE_BIT]      = fault_sticky[`FAULT_FUSE_BIT]; // RULE13
        fault_flags_word[`FAULT_SUPPLY_BIT]    = fault_sticky[`FAULT_SUPPLY_BIT]; // RULE14
    end

    // Read decode; addresses outside the bank read zero.
    always @* begin
        rd_mux = 8'h00;
        case (addr_i)
            `ADDR_Y_HIGH: begin
                rd_mux = y_axis_value_r[15:8]; // RULE1
            end
            `ADDR_Y_LOW: begin
                rd_mux = y_axis_value_r[7:0]; // RULE1
            end
            `ADDR_Z_HIGH: begin
                rd_mux = z_axis_value_r[15:8]; // RULE2
            end
            `ADDR_Z_LOW: begin
                rd_mux = z_axis_value_r[7:0]; // RULE2
            end
            `ADDR_CONV_STATE: begin
                rd_mux = conv_state_word;
            end
            `ADDR_ANGLE_HIGH: begin
                rd_mux = {3'h0, angle_value_r[12:8]}; // RULE8
            end
            `ADDR_ANGLE_LOW: begin
                rd_mux = angle_value_r[7:0]; // RULE8
            end
            `ADDR_VECTOR_SIZE: begin
                rd_mux = vector_size_r; // RULE9
            end
            `ADDR_FAULT_FLAGS: begin
                rd_mux = fault_flags_word;
            end
            default: begin
                rd_mux = 8'h00;
            end
        endcase
    end

    // Read data is captured one cycle after the strobe and then held, so the
    // serial shifter may take it at its own pace.
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rd_data_o  <= 8'h00;
            rd_valid_o <= 1'b0;
        end else begin
            rd_valid_o <= rd_en_i;
            if (rd_en_i) begin
                rd_data_o <= rd_mux;
            end
        end
    end

    // Registered mirrors for the pin driver and system logic.
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            result_ready_o <= 1'b0;
            diag_fail_o    <= 1'b0;
        end else begin
            result_ready_o <= ready_nxt; // RULE7
            diag_fail_o    <= diag_any; // RULE6
        end
    end

endmodule // hall_sensor_result_status_regs

/* core/hall_result_regs.vh */
// Offsets, bit positions, reset values and field widths of the result and status register bank.
`ifndef HALL_RESULT_REGS_VH
`define HALL_RESULT_REGS_VH

`define ADDR_Y_HIGH        8'h14
`define ADDR_Y_LOW         8'h15
`define ADDR_Z_HIGH        8'h16
`define ADDR_Z_LOW         8'h17
`define ADDR_CONV_STATE    8'h18
`define ADDR_ANGLE_HIGH    8'h19
`define ADDR_ANGLE_LOW     8'h1a
`define ADDR_VECTOR_SIZE   8'h1b
`define ADDR_FAULT_FLAGS   8'h1c

`define CONV_COUNT_MSB     7
`define CONV_COUNT_LSB     5
`define CONV_POWER_ON_BIT  4
`define CONV_DIAG_BIT      1
`define CONV_READY_BIT     0

`define FAULT_PIN_LEVEL_BIT 4
`define FAULT_OSC_BIT      3
`define FAULT_IRQ_PIN_BIT  2
`define FAULT_FUSE_BIT     1
`define FAULT_SUPPLY_BIT   0
`define FAULT_STICKY_W     4

`define RST_RESULT_BYTE    8'h00
`define RST_CONV_STATE     8'h10
`define RST_FAULT_FLAGS    8'h10
`define RST_SET_COUNT      3'h0
`define RST_POWER_ON       1'b1
`define RST_PIN_LEVEL      1'b1
`define RST_STICKY_FAULTS  4'h0

`define ANGLE_W            13
`define ANGLE_HIGH_W       5
`define RESULT_W           16
`define SET_COUNT_W        3

`endif

/* core/sticky_flag_bank.v */
// Bank of hardware-set, write-one-to-clear sticky flags.
`timescale 1ns/1ps

module sticky_flag_bank #(
    parameter                 WIDTH     = 4,
    parameter [WIDTH-1:0]     RESET_VAL = {WIDTH{1'b0}}
) (
    // Clock and reset
    input  wire               clk_sys_i,
    input  wire               rst_i,
    // Events and clears
    input  wire [WIDTH-1:0]   set_i,
    input  wire [WIDTH-1:0]   clr_i,
    // Flag state
    output wire [WIDTH-1:0]   flags_o
);

    reg [WIDTH-1:0] flags_r;

    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_flag
            // A set arriving in the clearing cycle is kept, so no event is lost.
            always @(posedge clk_sys_i or posedge rst_i) begin
                if (rst_i) begin
                    flags_r[g] <= RESET_VAL[g];
                end else if (set_i[g]) begin
                    flags_r[g] <= 1'b1;
                end else if (clr_i[g]) begin
                    flags_r[g] <= 1'b0;
                end
            end
        end
    endgenerate

    assign flags_o = flags_r;

endmodule // sticky_flag_bank

/* dv/hall_host_model.sv */
// Host model that issues register reads and writes on the internal access port.
`timescale 1ns/1ps
module hall_host_model (
    // Clock
    input  wire logic       clk_sys_i,
    // Register access
    output logic            rd_en_o,
    output logic            wr_en_o,
    output logic [7:0]      addr_o,
    output logic [7:0]      wr_data_o
);
    initial begin
        rd_en_o = 1'b0;
        wr_en_o = 1'b0;
        addr_o = 8'h00;
        wr_data_o = 8'h00;
    end
    // Released address and data are inverted so a stale value never reads as a valid one.
    task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        #1;
        rd_en_o = !w;
        wr_en_o = w;
        addr_o = a;
        wr_data_o = d;
        @(posedge clk_sys_i);
        #1;
        rd_en_o = 1'b0;
        wr_en_o = 1'b0;
        addr_o = ~a;
        wr_data_o = ~d;
    endtask
endmodule // hall_host_model

/* dv/hall_result_regs_properties.sv */
// Concurrent checks on the ports of the result and status register bank.
`timescale 1ns/1ps
module hall_result_regs_properties #(
    parameter ADDR_W   = 8,
    parameter RESULT_W = 16,
    parameter ANGLE_W  = 13
) (
    input wire logic                clk_sys_i,
    input wire logic                rst_i,
    input wire logic                rd_en_i,
    input wire logic                wr_en_i,
    input wire logic [ADDR_W-1:0]   addr_i,
    input wire logic [7:0]          wr_data_i,
    input wire logic [7:0]          rd_data_o,
    input wire logic                rd_valid_o,
    input wire logic                conv_start_i,
    input wire logic                set_done_i,
    input wire logic [RESULT_W-1:0] y_axis_value_i,
    input wire logic [RESULT_W-1:0] z_axis_value_i,
    input wire logic [ANGLE_W-1:0]  angle_value_i,
    input wire logic [7:0]          vector_size_i,
    input wire logic                oscillator_fault_i,
    input wire logic                irq_pin_fault_i,
    input wire logic                fuse_checksum_fault_i,
    input wire logic                supply_undervoltage_fault_i,
    input wire logic                irq_pin_level_i,
    input wire logic                result_ready_o,
    input wire logic                diag_fail_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    wire logic any_fault = oscillator_fault_i | irq_pin_fault_i | fuse_checksum_fault_i | supply_undervoltage_fault_i;
    sequence s_read(a); rd_en_i && addr_i == a; endsequence
    sequence s_unmapped; rd_en_i && (addr_i < 8'h14 || addr_i > 8'h1c); endsequence
    sequence s_fault_then_read; any_fault ##1 s_read(8'h18); endsequence
    a_read_answer: assert property (rd_en_i |=> rd_valid_o) else $error("read not answered");
    a_no_stray_valid: assert property (!rd_en_i |=> !rd_valid_o) else $error("stray read valid");
    a_ready_set: assert property (set_done_i |=> result_ready_o) else $error("ready not set");
    a_ready_clear: assert property (conv_start_i && !set_done_i |=> !result_ready_o)
        else $error("ready not cleared");
    a_ready_keep: assert property (!conv_start_i && !set_done_i |=> $stable(result_ready_o))
        else $error("ready changed alone");
    a_ready_mirror: assert property (s_read(8'h18) |=> rd_data_o[0] == $past(result_ready_o))
        else $error("ready bit differs");
    a_diag_live: assert property (any_fault |=> diag_fail_o) else $error("diag not raised");
    a_diag_sticky: assert property (s_fault_then_read |=> rd_data_o[1]) else $error("diag bit low");
    a_unmapped_zero: assert property (s_unmapped |=> rd_data_o == 8'h00) else $error("unmapped nonzero");
    a_conv_reserved: assert property (s_read(8'h18) |=> rd_data_o[3:2] == 2'b00)
        else $error("reserved bits set");
    a_angle_width: assert property (s_read(8'h19) |=> rd_data_o[7:5] == 3'b000)
        else $error("angle high bits set");
endmodule // hall_result_regs_properties
bind hall_sensor_result_status_regs hall_result_regs_properties #(.ADDR_W(ADDR_W), .RESULT_W(RESULT_W),
    .ANGLE_W(ANGLE_W)) hall_result_regs_properties_i (.*);

/* dv/tb.sv */
// Self-checking bench for the result and status register bank.
`timescale 1ns/1ps
module tb;
    logic        clk_sys_i, rst_i, rd_en_i, wr_en_i, rd_valid_o, result_ready_o, diag_fail_o;
    logic        conv_start_i, set_done_i, oscillator_fault_i, irq_pin_fault_i;
    logic        fuse_checksum_fault_i, supply_undervoltage_fault_i, irq_pin_level_i;
    logic        por, rdy;
    logic [7:0]  addr_i, wr_data_i, rd_data_o, vector_size_i, mag, q[$];
    logic [15:0] y_axis_value_i, z_axis_value_i, y, z;
    logic [12:0] angle_value_i, ang;
    logic [3:0]  flt;
    logic [2:0]  cnt;
    logic [31:0] seed;
    int          failures, n_checks, i, a;

    hall_sensor_result_status_regs hall_sensor_result_status_regs_i (.*);
    hall_host_model hall_host_model_i (.clk_sys_i(clk_sys_i), .rd_en_o(rd_en_i), .wr_en_o(wr_en_i),
        .addr_o(addr_i), .wr_data_o(wr_data_i));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] exp_reg(input logic [7:0] ad);
        case (ad)
            8'h14: return y[15:8];
            8'h15: return y[7:0];
            8'h16: return z[15:8];
            8'h17: return z[7:0];
            8'h18: return {cnt, por, 2'b00, |flt, rdy};
            8'h19: return {3'b000, ang[12:8]};
            8'h1a: return ang[7:0];
            8'h1b: return mag;
            8'h1c: return {3'b000, irq_pin_level_i, flt};
            default: return 8'h00;
        endcase
    endfunction
    task rd(input logic [7:0] ad);
        q.push_back(exp_reg(ad));
        hall_host_model_i.acc(1'b0, ad, 8'h00);
    endtask
    task wr(input logic [7:0] ad, input logic [7:0] d);
        hall_host_model_i.acc(1'b1, ad, d);
    endtask
    task chk(input logic [7:0] e);
        n_checks++;
        if (rd_data_o !== e) begin
            failures++;
            $display("MISMATCH t=%0t read %h expected %h", $time, rd_data_o, e);
        end
    endtask
    task chk_lvl(input logic got, input logic e);
        n_checks++;
        if (got !== e) begin
            failures++;
            $display("MISMATCH t=%0t status output %b expected %b", $time, got, e);
        end
    endtask
    task summarize();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    // Sampling on the falling edge keeps the compare clear of the launch edge.
    always @(negedge clk_sys_i) begin
        if (rd_valid_o === 1'b1) begin
            if (q.size() == 0) begin
                failures++;
                $display("MISMATCH t=%0t unexpected read answer", $time);
            end else
                chk(q.pop_front());
        end
    end
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        failures++;
        $display("MISMATCH t=%0t run timed out", $time);
        summarize();
    end
    initial begin
        {rst_i, conv_start_i, set_done_i, irq_pin_level_i, por, rdy} = 6'b100111;
        {oscillator_fault_i, irq_pin_fault_i, fuse_checksum_fault_i, supply_undervoltage_fault_i} = 4'h0;
        {y_axis_value_i, z_axis_value_i, angle_value_i, vector_size_i} = '0;
        {y, z, ang, mag, flt, cnt} = '0;
        rdy = 1'b0;
        seed = 32'h3ac551d0;
        repeat (2) @(posedge clk_sys_i);
        #1;
        rst_i = 1'b0;
        for (a = 8'h13; a <= 8'h1d; a++) rd(a[7:0]);
        wr(8'h14, 8'hff);
        rd(8'h14);
        $display("test reset done");
        for (i = 0; i < 9; i++) begin
            conv_start_i = 1'b1;
            @(posedge clk_sys_i);
            #1;
            conv_start_i = 1'b0;
            rdy = 1'b0;
            chk_lvl(result_ready_o, rdy);
            rd(8'h18);
            seed = lfsr(seed);
            {y, z} = seed;
            seed = lfsr(seed);
            {mag, ang} = seed[20:0];
            {y_axis_value_i, z_axis_value_i, angle_value_i, vector_size_i} = {y, z, ang, mag};
            set_done_i = 1'b1;
            @(posedge clk_sys_i);
            #1;
            set_done_i = 1'b0;
            {y_axis_value_i, z_axis_value_i} = ~{y, z};
            cnt = cnt + 3'h1;
            rdy = 1'b1;
            chk_lvl(result_ready_o, rdy);
            for (a = 8'h14; a <= 8'h1b; a++) rd(a[7:0]);
        end
        // A completion in the same cycle as a start must leave the set ready.
        {conv_start_i, set_done_i} = 2'b11;
        @(posedge clk_sys_i);
        #1;
        {conv_start_i, set_done_i} = 2'b00;
        {y, z} = {y_axis_value_i, z_axis_value_i};
        cnt = cnt + 3'h1;
        chk_lvl(result_ready_o, rdy);
        rd(8'h18);
        rd(8'h14);
        $display("test conversion done");
        wr(8'h18, 8'hef);
        rd(8'h18);
        wr(8'h18, 8'h10);
        por = 1'b0;
        rd(8'h18);
        $display("test power flag done");
        for (i = 0; i < 4; i++) begin
            flt = 4'h1 << i;
            {oscillator_fault_i, irq_pin_fault_i, fuse_checksum_fault_i, supply_undervoltage_fault_i} = flt;
            rd(8'h18);
            chk_lvl(diag_fail_o, |flt);
            {oscillator_fault_i, irq_pin_fault_i, fuse_checksum_fault_i, supply_undervoltage_fault_i} = 4'h0;
            rd(8'h1c);
            wr(8'h1c, {4'h0, ~flt});
            rd(8'h1c);
            // A clear that meets a live fault loses, so the flag must survive it.
            {oscillator_fault_i, irq_pin_fault_i, fuse_checksum_fault_i, supply_undervoltage_fault_i} = flt;
            wr(8'h1c, {4'h0, flt});
            {oscillator_fault_i, irq_pin_fault_i, fuse_checksum_fault_i, supply_undervoltage_fault_i} = 4'h0;
            rd(8'h1c);
            wr(8'h1c, {4'h0, flt});
            flt = 4'h0;
            rd(8'h1c);
            rd(8'h18);
            chk_lvl(diag_fail_o, |flt);
        end
        $display("test faults done");
        irq_pin_level_i = 1'b0;
        rd(8'h1c);
        irq_pin_level_i = 1'b1;
        rd(8'h1c);
        $display("test pin level done");
        for (i = 0; i < 10 && q.size() != 0; i++) @(posedge clk_sys_i);
        if (q.size() != 0) begin
            failures++;
            $display("MISMATCH t=%0t reads left unanswered", $time);
        end
        summarize();
    end
endmodule // tb
